// File: rtl/rvt_reset_vector_map.sv
// reset entry sequencer and vector table address generator
// behaviour in short:
// - after reset the block owns the fetch port and asks for the word at zero
// - the word at zero belongs to the core; this block only steps past it
// - the word at two is taken as the start-up address and loaded as is
// - once running, trap and interrupt levels are looked at while idle
// - the winner is latched together with its table address, so a source
//   that drops or changes during a slow fetch cannot move the fetch
// - traps always beat interrupts; inside each group the lower index wins,
//   which is the same as "the lower vector address wins"
// - the table select bit is read on the edge that latches the winner;
//   flipping it while a fetch is pending has no effect on that fetch
// limitations:
// - a request still high when the vector lands is taken again, so the core
//   must drop its request on the taken pulse
// - no user priority levels here; the fixed natural order decides everywhere
// - a reset mid-fetch simply abandons the fetch; memory must cope
`timescale 1ns/1ps
module rvt_reset_vector_map
	import rvt_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic [15:0] INTERRUPT_CONTROL_TWO,
	input wire logic [NUM_TRAPS-1:0] TRAP_REQ,
	input wire logic [NUM_VECTORS-1:0] INT_REQ,
	input wire logic [23:0] FETCH_DATA,
	input wire logic FETCH_VALID,
	output logic [23:0] FETCH_ADDR,
	output logic FETCH_REQ,
	output logic [23:0] PROGRAM_COUNTER,
	output logic VECTOR_TAKEN,
	output logic [7:0] VECTOR_SLOT,
	output logic RUNNING
);
	rvt_state_t state_r, state_nxt;
	logic [23:0] fetch_addr_r, fetch_addr_nxt;
	logic fetch_req_r, fetch_req_nxt;
	logic [23:0] pc_r, pc_nxt;
	logic taken_r, taken_nxt;
	logic [7:0] slot_r, slot_nxt;
	logic running_r, running_nxt;
	logic vec_pending_r, vec_pending_nxt;
	logic alt_table_select;
	logic [7:0] win_slot;
	logic win_valid;
	logic [23:0] win_addr;

	// pick the highest natural priority source: lowest slot index wins
	function automatic logic [7:0] rvt_pick(input logic [NUM_TRAPS-1:0] traps,
		input logic [NUM_VECTORS-1:0] ints);
		logic [7:0] s;
		s = 8'hFF;
		for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
			if (ints[i]) begin
				s = SLOT_INT0 + 8'(i);
			end
		end
		for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
			if (traps[t]) begin
				s = SLOT_OSC_FAIL + 8'(t);
			end
		end
		return s;
	endfunction

	assign alt_table_select = INTERRUPT_CONTROL_TWO[ALT_SEL_BIT];
	assign win_slot = rvt_pick(TRAP_REQ, INT_REQ);
	assign win_valid = (win_slot != 8'hFF);

	rvt_vec_addr u_vec_addr (
		.alt_sel(alt_table_select),
		.slot(win_slot),
		.vec_addr(win_addr)
	);

	// boot group: reset fetch is fixed, never arbitrated; vectors only once running
	always_comb begin
		state_nxt = state_r;
		running_nxt = running_r;
		unique case (state_r)
			RVT_ST_FETCH_JUMP: begin
				// the jump word is consumed by the core; we step to its target word
				if (FETCH_VALID) begin
					state_nxt = RVT_ST_FETCH_TARGET;
				end
			end
			RVT_ST_FETCH_TARGET: begin
				if (FETCH_VALID) begin
					running_nxt = 1'b1;
					state_nxt = RVT_ST_RUN;
				end
			end
			RVT_ST_RUN: begin
				// only a reset leaves this state
				state_nxt = RVT_ST_RUN;
			end
		endcase
	end

	// boot group registers; reset restarts the fixed entry walk
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= RVT_ST_FETCH_JUMP;
			running_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			running_r <= running_nxt;
		end
	end

	// fetch group: address, request, pending flag and latched slot
	always_comb begin
		fetch_addr_nxt = fetch_addr_r;
		fetch_req_nxt = fetch_req_r;
		slot_nxt = slot_r;
		vec_pending_nxt = vec_pending_r;
		unique case (state_r)
			RVT_ST_FETCH_JUMP: begin
				if (FETCH_VALID) begin
					fetch_addr_nxt = RESET_TARGET_ADDR;
				end
			end
			RVT_ST_FETCH_TARGET: begin
				if (FETCH_VALID) begin
					fetch_req_nxt = 1'b0;
				end
			end
			RVT_ST_RUN: begin
				if (vec_pending_r) begin
					if (FETCH_VALID) begin
						fetch_req_nxt = 1'b0;
						vec_pending_nxt = 1'b0;
					end
				end else if (win_valid) begin
					// latch the winner so a changing request cannot move the fetch
					fetch_addr_nxt = win_addr;
					slot_nxt = win_slot;
					fetch_req_nxt = 1'b1;
					vec_pending_nxt = 1'b1;
				end
			end
		endcase
	end

	// fetch group registers; first fetch is at address zero
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fetch_addr_r <= RESET_ADDR;
			fetch_req_r <= 1'b1;
			slot_r <= 8'h00;
			vec_pending_r <= 1'b0;
		end else begin
			fetch_addr_r <= fetch_addr_nxt;
			fetch_req_r <= fetch_req_nxt;
			slot_r <= slot_nxt;
			vec_pending_r <= vec_pending_nxt;
		end
	end

	// counter group: program counter loads and the taken pulse
	always_comb begin
		pc_nxt = pc_r;
		taken_nxt = 1'b0;
		unique case (state_r)
			RVT_ST_FETCH_JUMP: begin
				// jump word content is ignored; the counter stays at zero
				pc_nxt = pc_r;
			end
			RVT_ST_FETCH_TARGET: begin
				if (FETCH_VALID) begin
					pc_nxt = FETCH_DATA;
				end
			end
			RVT_ST_RUN: begin
				if (vec_pending_r && FETCH_VALID) begin
					pc_nxt = FETCH_DATA;
					taken_nxt = 1'b1;
				end
			end
		endcase
	end

	// counter group registers; reset clears the counter to zero
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pc_r <= RESET_ADDR;
			taken_r <= 1'b0;
		end else begin
			pc_r <= pc_nxt;
			taken_r <= taken_nxt;
		end
	end

	assign FETCH_ADDR = fetch_addr_r;
	assign FETCH_REQ = fetch_req_r;
	assign PROGRAM_COUNTER = pc_r;
	assign VECTOR_TAKEN = taken_r;
	assign VECTOR_SLOT = slot_r;
	assign RUNNING = running_r;
endmodule // rvt_reset_vector_map

// File: rtl/rvt_pkg.sv
// package: vector table layout, trap and slot encodings, widths
package rvt_pkg;
	localparam int ADDR_W = 24;
	localparam int SRC_W = 7;
	localparam logic [23:0] RESET_ADDR = 24'h000000;
	localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
	localparam logic [23:0] PRIMARY_BASE = 24'h000004;
	localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
	localparam logic [23:0] PRIMARY_INT0_ADDR = 24'h000014;
	localparam logic [23:0] ALTERNATE_INT0_ADDR = 24'h000114;
	localparam logic [7:0] SLOT_OSC_FAIL = 8'h01;
	localparam logic [7:0] SLOT_ADDR_ERR = 8'h02;
	localparam logic [7:0] SLOT_STACK_ERR = 8'h03;
	localparam logic [7:0] SLOT_MATH_ERR = 8'h04;
	localparam logic [7:0] SLOT_INT0 = 8'h08;
	localparam logic [6:0] LAST_VECTOR = 7'h75;
	localparam int NUM_VECTORS = 118;
	localparam int NUM_TRAPS = 4;
	localparam int ALT_SEL_BIT = 15;
	typedef enum logic [2:0] {
		RVT_ST_FETCH_JUMP = 3'b001,
		RVT_ST_FETCH_TARGET = 3'b010,
		RVT_ST_RUN = 3'b100
	} rvt_state_t;
endpackage

// File: rtl/rvt_vec_addr.sv
// slot index to vector address for the selected table
`timescale 1ns/1ps
module rvt_vec_addr
	import rvt_pkg::*;
(
	input wire logic alt_sel,
	input wire logic [7:0] slot,
	output logic [23:0] vec_addr
);
	// table base plus two bytes per slot, one program word each
	always_comb begin
		vec_addr = (alt_sel ? ALTERNATE_BASE : PRIMARY_BASE) + {15'h0000, slot, 1'b0};
	end
endmodule // rvt_vec_addr

// File: tb/rvt_properties.sv
// checker: port-level timing of reset entry and vector fetch
`timescale 1ns/1ps
module rvt_properties (
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic [15:0] INTERRUPT_CONTROL_TWO,
	input wire logic [3:0] TRAP_REQ,
	input wire logic [117:0] INT_REQ,
	input wire logic [23:0] FETCH_DATA,
	input wire logic FETCH_VALID,
	input wire logic [23:0] FETCH_ADDR,
	input wire logic FETCH_REQ,
	input wire logic [23:0] PROGRAM_COUNTER,
	input wire logic VECTOR_TAKEN,
	input wire logic [7:0] VECTOR_SLOT,
	input wire logic RUNNING
);
	logic [7:0] es;
	// expected winner: traps over ints, lowest index first
	always_comb begin
		es = 8'h00;
		for (int i = 117; i >= 0; i--) if (INT_REQ[i]) es = 8'(8 + i);
		for (int i = 3; i >= 0; i--) if (TRAP_REQ[i]) es = 8'(1 + i);
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	AST_BOOT0: assert property (!RUNNING && FETCH_VALID && FETCH_ADDR == 24'h000000
		|=> FETCH_REQ && FETCH_ADDR == 24'h000002) else $error("no target fetch");
	AST_TGT: assert property (!RUNNING && FETCH_VALID && FETCH_ADDR == 24'h000002
		|=> RUNNING && !FETCH_REQ && PROGRAM_COUNTER == $past(FETCH_DATA)) else $error("bad boot");
	AST_PC0: assert property (!RUNNING |-> PROGRAM_COUNTER == 24'h000000)
		else $error("pc not zero");
	AST_NOVEC: assert property (!RUNNING |-> !VECTOR_TAKEN) else $error("early vector");
	AST_VADDR: assert property ($rose(FETCH_REQ) && RUNNING |-> FETCH_ADDR ==
		($past(INTERRUPT_CONTROL_TWO[15]) ? 24'h000104 : 24'h000004) + {15'h0000, VECTOR_SLOT, 1'b0})
		else $error("bad vector address");
	AST_PRIO: assert property (RUNNING && !FETCH_REQ && !VECTOR_TAKEN && (|{TRAP_REQ, INT_REQ})
		|=> FETCH_REQ && VECTOR_SLOT == $past(es)) else $error("bad winner");
	AST_LOAD: assert property (RUNNING && FETCH_REQ && FETCH_VALID
		|=> VECTOR_TAKEN && PROGRAM_COUNTER == $past(FETCH_DATA)) else $error("bad load");
	AST_HOLD: assert property (FETCH_REQ && !FETCH_VALID |=> FETCH_REQ && $stable(FETCH_ADDR))
		else $error("fetch dropped");
	AST_PULSE: assert property (VECTOR_TAKEN |=> !VECTOR_TAKEN) else $error("long pulse");
	cover property ($rose(RUNNING));
	cover property (VECTOR_TAKEN && INTERRUPT_CONTROL_TWO[15]);
	cover property (VECTOR_TAKEN && VECTOR_SLOT < 8'h08);
endmodule // rvt_properties

// File: tb/rvt_prog_mem.sv
// program memory model answering the fetch port
`timescale 1ns/1ps
module rvt_prog_mem (
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic FETCH_REQ,
	input wire logic slow,
	input wire logic [23:0] FETCH_ADDR,
	output logic FETCH_VALID,
	output logic [23:0] FETCH_DATA
);
	logic [1:0] cnt;
	// one valid pulse a word; slow mode waits four cycles
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FETCH_VALID <= 1'b0;
			cnt <= 2'h0;
		end else begin
			FETCH_VALID <= FETCH_REQ && !FETCH_VALID && (!slow || cnt == 2'h3);
			cnt <= (FETCH_REQ && !FETCH_VALID) ? cnt + 2'h1 : 2'h0;
		end
	end
	// word is the inverted address; outside valid the bus shows something else
	assign FETCH_DATA = FETCH_VALID ? ~FETCH_ADDR : FETCH_ADDR;
endmodule // rvt_prog_mem

// File: tb/tb_reset_and_vector_table_map.sv
// testbench: boot, vector addresses, priority, reset in mid-fetch
`timescale 1ns/1ps
module tb_reset_and_vector_table_map;
	logic REF_CLK = 1'b0, ARST_N = 1'b0, slow = 1'b0;
	logic FETCH_VALID, FETCH_REQ, VECTOR_TAKEN, RUNNING;
	logic [15:0] INTERRUPT_CONTROL_TWO = 16'h0000;
	logic [3:0] TRAP_REQ = 4'h0;
	logic [117:0] INT_REQ = 118'h0;
	logic [23:0] FETCH_DATA, FETCH_ADDR, PROGRAM_COUNTER;
	logic [7:0] VECTOR_SLOT;
	int n_mismatch = 0, checks_done = 0;
	rvt_reset_vector_map uut (.*);
	rvt_prog_mem mem (.*);
	// clock generator
	initial forever #25 REF_CLK = ~REF_CLK;
	task chk(input string s, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task wait_run;
		for (int n = 0; n < 30 && RUNNING !== 1'b1; n++) @(negedge REF_CLK);
		chk("pc", 24'hFFFFFD, PROGRAM_COUNTER);
	endtask
	// requests held until the vector lands, dropped before relatch
	task take(input logic [3:0] tr, input logic [117:0] ir, input logic alt, input logic [7:0] s);
		@(negedge REF_CLK);
		{TRAP_REQ, INT_REQ, INTERRUPT_CONTROL_TWO} = {tr, ir, alt, 15'h0000};
		for (int n = 0; n < 30 && VECTOR_TAKEN !== 1'b1; n++) @(negedge REF_CLK);
		chk("slot", {16'h0000, s}, {16'h0000, VECTOR_SLOT});
		chk("pc", ~((alt ? 24'h000104 : 24'h000004) + {15'h0000, s, 1'b0}), PROGRAM_COUNTER);
		{TRAP_REQ, INT_REQ} = 122'h0;
	endtask
	task t_bounds;
		take(4'h0, 118'h1, 1'b0, 8'h08);
		take(4'h0, {1'b1, 117'h0}, 1'b1, 8'h7D);
		for (int i = 0; i < 4; i++) take(4'h1 << i, 118'h0, i[0], 8'(i + 1));
		take(4'hC, {118{1'b1}}, 1'b0, 8'h03);
		take(4'h0, 118'h6, 1'b1, 8'h09);
		$display("vector tests done");
	endtask
	// reset lands while a slow vector fetch is pending
	task t_reset;
		slow = 1'b1;
		INT_REQ = 118'h20;
		repeat (2) @(negedge REF_CLK);
		ARST_N = 1'b0;
		INT_REQ = 118'h0;
		@(negedge REF_CLK);
		chk("pc0", 24'h000000, PROGRAM_COUNTER);
		chk("adr0", 24'h000000, FETCH_ADDR);
		ARST_N = 1'b1;
		wait_run;
		take(4'h2, 118'h0, 1'b0, 8'h02);
		$display("reset test done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(negedge REF_CLK);
		ARST_N = 1'b1;
		wait_run;
		$display("boot test done");
		t_bounds;
		t_reset;
		print_verdict;
	end
	// watchdog at 8000 cycles, far beyond the few dozen cycles needed
	initial begin
		#400000;
		n_mismatch++;
		print_verdict;
	end
endmodule // tb_reset_and_vector_table_map
bind rvt_reset_vector_map rvt_properties props (.*);
